// ---- core/mnse_defines.svh ----
// Constants for the multiply, negate and return-stack execution block.
`ifndef MNSE_DEFINES_SVH
`define MNSE_DEFINES_SVH
`define MNSE_ILO_LIMIT     8'h5F
`define MNSE_OPH_STORE     7'h37
`define MNSE_OPH_NEGATE    7'h36
`define MNSE_OPH_MULFILE   7'h01
`define MNSE_OPH_MULLIT    8'h0D
`define MNSE_OPH_NOPFREE   4'hF
`define MNSE_OP_POP        16'h0006
`define MNSE_OP_PUSH       16'h0005
`define MNSE_OP_IDLE       16'h0000
`define MNSE_PC_STEP       21'h000002
`define MNSE_FLAG_C        0
`define MNSE_FLAG_DIGIT    1
`define MNSE_FLAG_Z        2
`define MNSE_FLAG_OVER     3
`define MNSE_FLAG_N        4
`endif

// ---- core/mnse_pkg.sv ----
// Types for the multiply, negate and return-stack execution block.
package mnse_pkg;
  typedef enum logic [1:0] {
    MNSE_Q1,
    MNSE_Q2,
    MNSE_Q3,
    MNSE_Q4
  } mnse_phase_t;

  typedef struct packed {
    logic        write;
    logic [11:0] addr;
    logic [7:0]  data;
  } mnse_file_wr_t;

  typedef struct packed {
    logic       write;
    logic [7:0] high;
    logic [7:0] low;
  } mnse_prod_t;

  typedef struct packed {
    logic        push;
    logic        pop;
    logic [20:0] value;
  } mnse_stack_t;
endpackage : mnse_pkg

// ---- core/mnse_exec.sv ----
// Execution of store-working, multiply, negate, no-operation and return-stack push/pop.
`timescale 1ns/1ns
`include "mnse_defines.svh"
module mnse_exec #(
  parameter int STACK_DEPTH = 31
) (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   instr_valid,
  input  wire logic [15:0]            instr,
  input  wire logic                   second_word,
  input  wire logic [20:0]            pc,
  input  wire logic [7:0]             working_reg,
  input  wire logic [3:0]             bank_select_register,
  input  wire logic                   extended_enable,
  input  wire logic [7:0]             index_base,
  input  wire logic [7:0]             file_rd_data,
  input  wire logic [4:0]             status_in,
  output logic [11:0]                 file_rd_addr,
  output mnse_pkg::mnse_file_wr_t     file_wr,
  output mnse_pkg::mnse_prod_t        prod,
  output logic [7:0]                  product_high_byte,
  output logic [7:0]                  product_low_byte,
  output logic                        status_wr,
  output logic [4:0]                  status_out,
  output mnse_pkg::mnse_stack_t       stack_op,
  output logic [20:0]                 top_of_return_stack,
  output logic [4:0]                  stack_ptr,
  output mnse_pkg::mnse_phase_t       phase
);
  logic                    rst_s1;
  logic                    rst_n;
  mnse_pkg::mnse_phase_t   next_phase;
  logic [15:0]             op;
  logic [15:0]             next_op;
  logic [7:0]              opnd;
  logic [7:0]              next_opnd;
  logic [11:0]             next_file_rd_addr;
  mnse_pkg::mnse_file_wr_t next_file_wr;
  mnse_pkg::mnse_prod_t    next_prod;
  logic [7:0]              next_product_high_byte;
  logic [7:0]              next_product_low_byte;
  logic                    next_status_wr;
  logic [4:0]              next_status_out;
  mnse_pkg::mnse_stack_t   next_stack_op;
  logic [20:0]             stk [STACK_DEPTH];
  logic [4:0]              next_stack_ptr;
  logic [20:0]             next_top_of_return_stack;

  // Reset is released through two flip-flops.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Resolves a file operand to a 12-bit data address.
  function automatic logic [11:0] file_addr(input logic [15:0] w, input logic [3:0] bank,
                                            input logic ext, input logic [7:0] base);
    logic [7:0] f;
    f = w[7:0];
    if (w[8])
      file_addr = {bank, f};
    else if (ext && f <= `MNSE_ILO_LIMIT)
      file_addr = {4'h0, 8'(base + f)};
    else if (f[7])
      file_addr = {4'hF, f};
    else
      file_addr = {4'h0, f};
  endfunction : file_addr

  function automatic logic is_op(input logic [15:0] w, input logic [6:0] hi7);
    is_op = (w[15:9] == hi7);
  endfunction : is_op

  always_comb begin
    next_phase             = phase;
    next_op                = op;
    next_opnd              = opnd;
    next_file_rd_addr      = file_rd_addr;
    next_file_wr           = '0;
    next_prod              = '0;
    next_product_high_byte = product_high_byte;
    next_product_low_byte  = product_low_byte;
    next_status_wr         = 1'b0;
    next_status_out        = status_out;
    next_stack_op          = '0;
    unique case (phase)
      mnse_pkg::MNSE_Q1: begin
        if (instr_valid) begin
          next_phase = mnse_pkg::MNSE_Q2;
          // A lone 1111 word is a no-operation, never a file or stack action.
          next_op = (instr[15:12] == `MNSE_OPH_NOPFREE && !second_word)
                    ? `MNSE_OP_IDLE : instr;
          next_file_rd_addr = file_addr(instr, bank_select_register,
                                        extended_enable, index_base);
        end
      end
      mnse_pkg::MNSE_Q2: begin
        next_phase = mnse_pkg::MNSE_Q3;
        next_opnd  = (op[15:8] == `MNSE_OPH_MULLIT) ? op[7:0] : file_rd_data;
        if (op == `MNSE_OP_PUSH) begin
          next_stack_op.push  = 1'b1;
          next_stack_op.value = 21'(pc + `MNSE_PC_STEP);
        end
      end
      mnse_pkg::MNSE_Q3: begin
        next_phase = mnse_pkg::MNSE_Q4;
        if (op == `MNSE_OP_POP)
          next_stack_op.pop = 1'b1;
      end
      mnse_pkg::MNSE_Q4: begin
        next_phase = mnse_pkg::MNSE_Q1;
        if (op[15:8] == `MNSE_OPH_MULLIT || is_op(op, `MNSE_OPH_MULFILE)) begin
          // Flags are left alone here.
          {next_prod.high, next_prod.low} =
            16'({8'h00, working_reg} * {8'h00, opnd});
          next_prod.write        = 1'b1;
          next_product_high_byte = next_prod.high;
          next_product_low_byte  = next_prod.low;
        end else if (is_op(op, `MNSE_OPH_STORE)) begin
          next_file_wr = '{write: 1'b1, addr: file_rd_addr, data: working_reg};
        end else if (is_op(op, `MNSE_OPH_NEGATE)) begin
          next_file_wr = '{write: 1'b1, addr: file_rd_addr,
                           data: 8'(~opnd + 8'h01)};
          next_status_wr = 1'b1;
          next_status_out = status_in;
          next_status_out[`MNSE_FLAG_N]  = next_file_wr.data[7];
          next_status_out[`MNSE_FLAG_Z]  = (next_file_wr.data == 8'h00);
          next_status_out[`MNSE_FLAG_OVER]  = (opnd == 8'h80);
          next_status_out[`MNSE_FLAG_C]     = (opnd == 8'h00);
          next_status_out[`MNSE_FLAG_DIGIT] = (opnd[3:0] == 4'h0);
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase             <= mnse_pkg::MNSE_Q1;
      op                <= 16'h0000;
      opnd              <= 8'h00;
      file_rd_addr      <= 12'h000;
      file_wr           <= '0;
      prod              <= '0;
      product_high_byte <= 8'h00;
      product_low_byte  <= 8'h00;
      status_wr         <= 1'b0;
      status_out        <= 5'h00;
      stack_op          <= '0;
    end else begin
      phase             <= next_phase;
      op                <= next_op;
      opnd              <= next_opnd;
      file_rd_addr      <= next_file_rd_addr;
      file_wr           <= next_file_wr;
      prod              <= next_prod;
      product_high_byte <= next_product_high_byte;
      product_low_byte  <= next_product_low_byte;
      status_wr         <= next_status_wr;
      status_out        <= next_status_out;
      stack_op          <= next_stack_op;
    end
  end

  // Return stack: push stores one slot up, pop exposes the slot below.
  always_comb begin
    next_stack_ptr           = stack_ptr;
    next_top_of_return_stack = top_of_return_stack;
    if (stack_op.push) begin
      next_stack_ptr           = 5'(stack_ptr + 5'h01);
      next_top_of_return_stack = stack_op.value;
    end else if (stack_op.pop) begin
      next_stack_ptr           = 5'(stack_ptr - 5'h01);
      next_top_of_return_stack = stk[5'(stack_ptr - 5'h01)];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_ptr           <= 5'h00;
      top_of_return_stack <= 21'h000000;
    end else begin
      stack_ptr           <= next_stack_ptr;
      top_of_return_stack <= next_top_of_return_stack;
    end
  end

  always_ff @(posedge clk) begin
    if (stack_op.push)
      stk[stack_ptr] <= top_of_return_stack;
  end

  mul_prod_a: assert property (@(posedge clk) disable iff (!rst_n)
    prod.write |-> {product_high_byte, product_low_byte} == {prod.high, prod.low}
      && {prod.high, prod.low} == 16'({8'h00, $past(working_reg)} * {8'h00, $past(opnd)}))
    else $error("product pair does not match");
  mul_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
    prod.write |-> !status_wr)
    else $error("multiply touched flags");
  neg_value_a: assert property (@(posedge clk) disable iff (!rst_n)
    status_wr |-> file_wr.write && 8'(file_wr.data + $past(opnd)) == 8'h00)
    else $error("negate result wrong");
  neg_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    status_wr |-> status_out[`MNSE_FLAG_Z] == (file_wr.data == 8'h00))
    else $error("negate zero flag wrong");
  push_top_a: assert property (@(posedge clk) disable iff (!rst_n)
    stack_op.push |=> top_of_return_stack == $past(stack_op.value)
      && stack_ptr == 5'($past(stack_ptr) + 5'h01))
    else $error("push did not load top");
  pop_ptr_a: assert property (@(posedge clk) disable iff (!rst_n)
    stack_op.pop |=> stack_ptr == 5'($past(stack_ptr) - 5'h01))
    else $error("pop did not step down");
  phase_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
    phase == mnse_pkg::MNSE_Q2 |=> phase == mnse_pkg::MNSE_Q3 ##1 phase == mnse_pkg::MNSE_Q4
      ##1 phase == mnse_pkg::MNSE_Q1)
    else $error("phase sequence broken");
  bank_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    phase == mnse_pkg::MNSE_Q2 && op[8] |-> file_rd_addr[11:8] == $past(bank_select_register))
    else $error("bank select not used");
  store_w_a: assert property (@(posedge clk) disable iff (!rst_n)
    file_wr.write && !status_wr |-> file_wr.data == $past(working_reg))
    else $error("store wrote wrong data");
endmodule : mnse_exec

// ---- dv/mnse_exec_tb.sv ----
// Self-checking bench for the multiply, negate and return-stack execution block.
`timescale 1ns/1ns
module mul_negate_stack_ops_exec_tb_top;
  logic                    clk;
  logic                    resetn;
  logic                    instr_valid;
  logic                    second_word;
  logic                    extended_enable;
  logic [15:0]             instr;
  logic [20:0]             pc;
  logic [7:0]              working_reg;
  logic [3:0]              bank_select_register;
  logic [7:0]              index_base;
  logic [7:0]              file_rd_data;
  logic [4:0]              status_in;
  logic [11:0]             file_rd_addr;
  mnse_pkg::mnse_file_wr_t file_wr;
  mnse_pkg::mnse_prod_t    prod;
  logic [7:0]              product_high_byte;
  logic [7:0]              product_low_byte;
  logic                    status_wr;
  logic [4:0]              status_out;
  mnse_pkg::mnse_stack_t   stack_op;
  logic [20:0]             top_of_return_stack;
  logic [4:0]              stack_ptr;
  mnse_pkg::mnse_phase_t   phase;
  logic [43:0]             got;
  logic [11:0]             rd_addr;
  logic [7:0]              ph_got;
  logic [22:0]             stk_got;
  int                      err_count;
  int                      checks_done;

  mnse_exec #(.STACK_DEPTH(31)) uut (
    .clk(clk), .resetn(resetn), .instr_valid(instr_valid), .instr(instr),
    .second_word(second_word), .pc(pc), .working_reg(working_reg),
    .bank_select_register(bank_select_register), .extended_enable(extended_enable),
    .index_base(index_base), .file_rd_data(file_rd_data), .status_in(status_in),
    .file_rd_addr(file_rd_addr), .file_wr(file_wr), .prod(prod),
    .product_high_byte(product_high_byte), .product_low_byte(product_low_byte),
    .status_wr(status_wr), .status_out(status_out), .stack_op(stack_op),
    .top_of_return_stack(top_of_return_stack), .stack_ptr(stack_ptr), .phase(phase)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [43:0] seen, input logic [43:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // Called at a rising edge; collects every result pulse of one instruction cycle.
  task automatic run(input logic [15:0] w, input logic sec);
    int n;
    instr <= w;
    second_word <= sec;
    instr_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (phase !== mnse_pkg::MNSE_Q1 && n < 8);
    if (n >= 8) begin
      err_count++;
      stop_test();
    end
    @(posedge clk);
    instr_valid <= 1'b0;
    got = '0;
    ph_got = '0;
    stk_got = '0;
    repeat (4) begin
      @(negedge clk);
      ph_got = {ph_got[5:0], phase};
      if (stack_op.push === 1'b1 || stack_op.pop === 1'b1)
        stk_got = {stack_op.push, stack_op.pop, stack_op.value};
      if (file_wr.write === 1'b1) got[43:23] = {1'b1, file_wr.addr, file_wr.data};
      if (prod.write === 1'b1) got[22:6] = {1'b1, prod.high, prod.low};
      if (status_wr === 1'b1) got[5:0] = {1'b1, status_out};
      if (phase === mnse_pkg::MNSE_Q3) rd_addr = file_rd_addr;
    end
    @(posedge clk);
  endtask : run

  initial begin
    err_count = 0;
    checks_done = 0;
    resetn = 1'b0;
    instr_valid = 1'b0;
    instr = 16'h0000;
    second_word = 1'b0;
    pc = 21'h000000;
    working_reg = 8'h00;
    bank_select_register = 4'h5;
    extended_enable = 1'b0;
    index_base = 8'h10;
    file_rd_data = 8'h00;
    status_in = 5'h00;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    working_reg <= 8'hE2;
    run(16'h0DC4, 1'b0);
    check(got, {21'h0, 17'h1AD08, 6'h00});
    check({28'h0, product_high_byte, product_low_byte}, 44'h000_0000_AD08);
    check({36'h0, ph_got}, {36'h0, mnse_pkg::MNSE_Q2, mnse_pkg::MNSE_Q3,
                            mnse_pkg::MNSE_Q4, mnse_pkg::MNSE_Q1});
    run(16'h0D00, 1'b0);
    check(got, {21'h0, 17'h10000, 6'h00});
    working_reg <= 8'hFF;
    run(16'h0DFF, 1'b0);
    check(got, {21'h0, 17'h1FE01, 6'h00});
    working_reg <= 8'hC4;
    file_rd_data <= 8'hB5;
    run(16'h03B5, 1'b0);
    check(got, {21'h0, 17'h18A94, 6'h00});
    check({32'h0, rd_addr}, 44'h000_0000_05B5);
    file_rd_data <= 8'h3A;
    run(16'h6C90, 1'b0);
    check(got, {21'h1F90C6, 17'h0, 6'h30});
    file_rd_data <= 8'h00;
    run(16'h6C90, 1'b0);
    check(got, {21'h1F9000, 17'h0, 6'h27});
    file_rd_data <= 8'h80;
    run(16'h6C90, 1'b0);
    check(got, {21'h1F9080, 17'h0, 6'h3A});
    working_reg <= 8'h4F;
    run(16'h6E20, 1'b0);
    check(got, {21'h10204F, 17'h0, 6'h00});
    run(16'h6F20, 1'b0);
    check(got, {21'h15204F, 17'h0, 6'h00});
    extended_enable <= 1'b1;
    run(16'h6E20, 1'b0);
    check(got, {21'h10304F, 17'h0, 6'h00});
    run(16'h6E5F, 1'b0);
    check(got, {21'h106F4F, 17'h0, 6'h00});
    run(16'h6E60, 1'b0);
    check(got, {21'h10604F, 17'h0, 6'h00});
    pc <= 21'h000124;
    run(16'h0005, 1'b0);
    check({18'h0, top_of_return_stack, stack_ptr}, {18'h0, 21'h000126, 5'h01});
    check({21'h0, stk_got}, {21'h0, 2'h2, 21'h000126});
    pc <= 21'h000345;
    run(16'h0005, 1'b0);
    check({18'h0, top_of_return_stack, stack_ptr}, {18'h0, 21'h000347, 5'h02});
    run(16'h0006, 1'b0);
    check({18'h0, top_of_return_stack, stack_ptr}, {18'h0, 21'h000126, 5'h01});
    check({42'h0, stk_got[22:21]}, 44'h001);
    check(got, 44'h0);
    run(16'h0000, 1'b0);
    check(got, 44'h0);
    run(16'hF123, 1'b0);
    check(got, 44'h0);
    run(16'hF123, 1'b1);
    check(got, 44'h0);
    check({23'h0, product_high_byte, product_low_byte, stack_ptr},
          {23'h0, 8'h8A, 8'h94, 5'h01});
    stop_test();
  end
endmodule : mul_negate_stack_ops_exec_tb_top
